// File: rtl/gpc_cycle_tick.sv
// divider producing the 5 ms process data cycle enable
`timescale 1ns/1ps
module gpc_cycle_tick #(
  parameter int CYCLE_CLKS = gpc_pkg::CYCLE_CLKS
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // synchronous reset, active low
  output logic tick // one-cycle pulse per exchange cycle
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic wrap;
  assign wrap = (cnt_reg == 32'(CYCLE_CLKS - 1));
  assign cnt_next = wrap ? 32'h0 : cnt_reg + 32'h1;
  assign tick = wrap;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // gpc_cycle_tick

// File: rtl/gpc_pkg.sv
// shared constants for the gripper process data command interpreter
package gpc_pkg;
  // command codes, one-hot except the all-zero idle code
  localparam logic [15:0] CMD_IDLE = 16'h0000;
  localparam logic [15:0] CMD_TAKE_OVER = 16'h0001;
  localparam logic [15:0] CMD_STORE_RECIPE = 16'h0002;
  localparam logic [15:0] CMD_CLEAR_DIR = 16'h0004;
  localparam logic [15:0] CMD_TEACH = 16'h0008;
  localparam logic [15:0] CMD_CALIBRATE = 16'h0080;
  localparam logic [15:0] CMD_GO_OUTER = 16'h0100;
  localparam logic [15:0] CMD_GO_INNER = 16'h0200;
  localparam logic [15:0] CMD_FAULT_ACK = 16'h8000;
  // state word bit positions
  localparam int SW_BOOT = 6;
  localparam int SW_AT_OUTER = 8;
  localparam int SW_AT_TEACH = 9;
  localparam int SW_AT_INNER = 10;
  localparam int SW_UNDEF = 11;
  localparam int SW_TAKEOVER_ACK = 12;
  localparam int SW_DIR_OUTER = 13;
  localparam int SW_DIR_INNER = 14;
  localparam int SW_FAULT = 15;
  // travel profile codes
  localparam logic [7:0] PROF_60 = 8'h3c;
  localparam logic [7:0] PROF_63 = 8'h3f;
  localparam logic [7:0] PROF_70 = 8'h46;
  localparam logic [7:0] PROF_73 = 8'h49;
  localparam logic [7:0] PROF_100 = 8'h64;
  localparam logic [7:0] PROF_103 = 8'h67;
  // recipe store
  localparam logic [7:0] RECIPE_MAX = 8'h20;
  localparam int RECIPE_DEPTH = 33;
  // reset values of active parameters
  localparam logic [7:0] PROFILE_RESET = 8'h64;
  localparam logic [7:0] FORCE_RESET = 8'h01;
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int CYCLE_US = 5000;
  localparam int CYCLE_CLKS = CLK_HZ / 1000000 * CYCLE_US;
  localparam int HOLD_MS = 500;
  localparam int HOLD_CYCLES = HOLD_MS * 1000 / CYCLE_US;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_PART_LOST = 16'h0001;
endpackage

// File: rtl/gpc_sync3.sv
// three-stage synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module gpc_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [W-1:0] d_async, // asynchronous input
  output logic [W-1:0] q // filtered level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  assign q = q_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_reg <= s3_reg;
      end
    end
  end
endmodule // gpc_sync3

// File: rtl/gpc_top.sv
`timescale 1ns/1ps
module gpc_top #(
  parameter int CYCLE_CLKS = gpc_pkg::CYCLE_CLKS, // clocks per exchange cycle
  parameter bit REDUCED = 1'b0 // reduced variant: profiles 60, 70, 100 only
) (
  input wire logic clk_sys, // 50 MHz system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [15:0] command_word, // cyclic command word from master
  input wire logic [7:0] travel_profile_code, // requested travel profile
  input wire logic [7:0] recipe_index, // recipe selection, 0 = cyclic data
  input wire logic [15:0] expected_part_position, // expected workpiece position
  input wire logic [7:0] force_level, // grip force level
  input wire logic [7:0] position_window, // tolerance around expected position
  input wire logic [15:0] jaw_pos_in, // measured jaw position
  input wire logic at_outer_in, // jaw sits at outer end position
  input wire logic at_inner_in, // jaw sits at inner end position
  input wire logic part_lost_in, // workpiece slipped while held
  input wire logic [15:0] fault_in, // fault code raised by drive, 0 none
  input wire logic fault_resettable_in, // raised fault may be acknowledged
  output logic [15:0] state_word, // returned state word
  output logic [15:0] fault_code, // returned fault code
  output logic [15:0] jaw_position_now, // returned jaw position
  output logic move_outer, // drive toward outer end position
  output logic move_inner, // drive toward inner end position
  output logic grip_force_move, // current move uses selected force and speed
  output logic hold_feed, // holding current feed active
  output logic calibrate, // recalibration request pulse
  output logic [7:0] active_force, // active force level
  output logic [7:0] active_window, // active position window
  output logic [15:0] active_position // active expected position
);
  typedef enum logic [1:0] {
    GPC_IDLE = 2'b00,
    GPC_MOVE = 2'b01,
    GPC_HOLD = 2'b11
  } gpc_mot_e;

  logic tick;
  logic [15:0] jaw_s;
  logic [2:0] end_s;
  logic at_outer_s, at_inner_s, lost_s;

  gpc_cycle_tick #(.CYCLE_CLKS(CYCLE_CLKS)) u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick(tick)
  );
  gpc_sync3 #(.W(16)) u_sync_pos (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d_async(jaw_pos_in),
    .q(jaw_s)
  );
  gpc_sync3 #(.W(3)) u_sync_end (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d_async({part_lost_in, at_inner_in, at_outer_in}),
    .q(end_s)
  );
  assign at_outer_s = end_s[0];
  assign at_inner_s = end_s[1];
  assign lost_s = end_s[2];

  // recipe store: profile, force, window, position
  localparam int RECIPE_DEPTH = gpc_pkg::RECIPE_DEPTH;
  logic [7:0] rec_prof [RECIPE_DEPTH];
  logic [7:0] rec_force [RECIPE_DEPTH];
  logic [7:0] rec_win [RECIPE_DEPTH];
  logic [15:0] rec_pos [RECIPE_DEPTH];

  function automatic logic cmd_valid(input logic [15:0] c);
    cmd_valid = (c == gpc_pkg::CMD_IDLE) || (c == gpc_pkg::CMD_TAKE_OVER) ||
      (c == gpc_pkg::CMD_STORE_RECIPE) || (c == gpc_pkg::CMD_CLEAR_DIR) ||
      (c == gpc_pkg::CMD_TEACH) || (c == gpc_pkg::CMD_CALIBRATE) ||
      (c == gpc_pkg::CMD_GO_OUTER) || (c == gpc_pkg::CMD_GO_INNER) ||
      (c == gpc_pkg::CMD_FAULT_ACK);
  endfunction

  function automatic logic prof_valid(input logic [7:0] p, input logic red);
    prof_valid = (p == gpc_pkg::PROF_60) || (p == gpc_pkg::PROF_70) ||
      (p == gpc_pkg::PROF_100) || (!red && ((p == gpc_pkg::PROF_63) ||
      (p == gpc_pkg::PROF_73) || (p == gpc_pkg::PROF_103)));
  endfunction

  logic [15:0] cmd_reg, cmd_prev_reg;
  wire cmd_ok = cmd_valid(cmd_reg);
  wire cmd_new = tick && cmd_ok && (cmd_reg != cmd_prev_reg);
  wire do_take = cmd_new && (cmd_reg == gpc_pkg::CMD_TAKE_OVER);
  wire do_store = cmd_new && (cmd_reg == gpc_pkg::CMD_STORE_RECIPE);
  wire do_clear = cmd_new && (cmd_reg == gpc_pkg::CMD_CLEAR_DIR);
  wire do_teach = cmd_new && (cmd_reg == gpc_pkg::CMD_TEACH);
  wire do_cal = cmd_new && (cmd_reg == gpc_pkg::CMD_CALIBRATE);
  wire do_outer = cmd_new && (cmd_reg == gpc_pkg::CMD_GO_OUTER);
  wire do_inner = cmd_new && (cmd_reg == gpc_pkg::CMD_GO_INNER);
  wire do_ack = cmd_new && (cmd_reg == gpc_pkg::CMD_FAULT_ACK);
  wire do_stop = tick && (cmd_reg == gpc_pkg::CMD_IDLE);

  wire idx_ok = (recipe_index <= gpc_pkg::RECIPE_MAX);
  wire [5:0] idx = recipe_index[5:0];
  wire use_rec = (recipe_index != 8'h00) && idx_ok;
  wire [7:0] new_prof = use_rec ? rec_prof[idx] : travel_profile_code;
  wire take_prof_ok = prof_valid(new_prof, REDUCED);

  logic takeover_ack_reg;
  logic [7:0] prof_reg, force_reg, win_reg;
  logic [15:0] pos_reg;
  logic dir_outer_reg, dir_inner_reg;
  logic [15:0] fault_reg;
  logic fault_res_reg;
  logic cal_reg;
  logic boot_reg;
  gpc_mot_e mot_reg;
  logic mot_to_inner_reg;
  logic [7:0] hold_cnt_reg;
  logic lost_msg_reg;

  wire hold_prof = (prof_reg == gpc_pkg::PROF_103) ||
    (prof_reg == gpc_pkg::PROF_63 && mot_to_inner_reg) ||
    (prof_reg == gpc_pkg::PROF_73 && !mot_to_inner_reg);
  wire arrived = mot_to_inner_reg ? at_inner_s : at_outer_s;
  // one event per loss, so an acknowledged message is not raised again
  wire lost_evt = (mot_reg == GPC_HOLD) && lost_s;
  wire start_outer = do_outer && !dir_outer_reg && mot_reg == GPC_IDLE;
  wire start_inner = do_inner && !dir_inner_reg && mot_reg == GPC_IDLE;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmd_reg <= 16'h0;
      cmd_prev_reg <= 16'h0;
    end else if (tick) begin
      cmd_reg <= command_word;
      cmd_prev_reg <= cmd_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_store && idx_ok) begin
      rec_prof[idx] <= travel_profile_code;
      rec_force[idx] <= force_level;
      rec_win[idx] <= position_window;
      rec_pos[idx] <= expected_part_position;
    end else if (do_teach && use_rec) begin
      rec_pos[idx] <= jaw_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      takeover_ack_reg <= 1'b0;
      prof_reg <= gpc_pkg::PROFILE_RESET;
      force_reg <= gpc_pkg::FORCE_RESET;
      win_reg <= 8'h00;
      pos_reg <= 16'h0;
      boot_reg <= 1'b0;
    end else begin
      boot_reg <= 1'b1;
      if (do_take) begin
        takeover_ack_reg <= 1'b1;
        if (take_prof_ok) begin
          prof_reg <= new_prof;
        end
        force_reg <= use_rec ? rec_force[idx] : force_level;
        win_reg <= use_rec ? rec_win[idx] : position_window;
        pos_reg <= use_rec ? rec_pos[idx] : expected_part_position;
      end else if (do_stop) begin
        takeover_ack_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mot_reg <= GPC_IDLE;
      mot_to_inner_reg <= 1'b0;
      hold_cnt_reg <= 8'h0;
      dir_outer_reg <= 1'b0;
      dir_inner_reg <= 1'b0;
      cal_reg <= 1'b0;
      lost_msg_reg <= 1'b0;
    end else begin
      cal_reg <= do_cal;
      if (do_clear) begin
        dir_outer_reg <= 1'b0;
        dir_inner_reg <= 1'b0;
      end
      case (mot_reg)
        GPC_IDLE: begin
          if (start_outer || start_inner) begin
            mot_reg <= GPC_MOVE;
            mot_to_inner_reg <= start_inner;
            dir_outer_reg <= start_outer;
            dir_inner_reg <= start_inner;
            lost_msg_reg <= 1'b0;
          end
        end
        GPC_MOVE: begin
          if (arrived) begin
            mot_reg <= (hold_prof && !lost_msg_reg) ? GPC_HOLD : GPC_IDLE;
            hold_cnt_reg <= 8'(gpc_pkg::HOLD_CYCLES);
          end
        end
        GPC_HOLD: begin
          if (lost_s) begin
            lost_msg_reg <= 1'b1;
            mot_reg <= GPC_MOVE;
          end else if (tick) begin
            if (hold_cnt_reg == 8'h1) begin
              mot_reg <= GPC_IDLE;
            end
            hold_cnt_reg <= hold_cnt_reg - 8'h1;
          end
        end
        default: mot_reg <= GPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fault_reg <= gpc_pkg::FAULT_NONE;
      fault_res_reg <= 1'b0;
    end else if (fault_in != gpc_pkg::FAULT_NONE) begin
      // new fault wins over acknowledge
      fault_reg <= fault_in;
      fault_res_reg <= fault_resettable_in;
    end else if (lost_evt && (fault_reg == gpc_pkg::FAULT_NONE || (do_ack && fault_res_reg))) begin
      // part lost message wins over a same-cycle acknowledge
      fault_reg <= gpc_pkg::FAULT_PART_LOST;
      fault_res_reg <= 1'b1;
    end else if (do_ack && fault_res_reg) begin
      fault_reg <= gpc_pkg::FAULT_NONE;
    end
  end

  wire in_grip = (prof_reg == gpc_pkg::PROF_60) || (prof_reg == gpc_pkg::PROF_63);
  wire out_grip = (prof_reg == gpc_pkg::PROF_70) || (prof_reg == gpc_pkg::PROF_73);
  wire moving = (mot_reg != GPC_IDLE);
  assign move_outer = moving && !mot_to_inner_reg;
  assign move_inner = moving && mot_to_inner_reg;
  assign grip_force_move = moving &&
    (mot_to_inner_reg ? !out_grip : !in_grip);
  assign hold_feed = (mot_reg == GPC_HOLD);
  assign calibrate = cal_reg;
  assign active_force = force_reg;
  assign active_window = win_reg;
  assign active_position = pos_reg;

  wire [16:0] win_hi = {1'b0, pos_reg} + {9'h0, win_reg};
  wire at_teach = ({1'b0, jaw_s} <= win_hi) &&
    (jaw_s >= ((pos_reg > {8'h0, win_reg}) ? pos_reg - {8'h0, win_reg} : 16'h0));

  logic [15:0] sw_reg, fc_reg, jp_reg;
  logic [15:0] sw_next;
  always_comb begin
    sw_next = 16'h0;
    sw_next[gpc_pkg::SW_BOOT] = boot_reg;
    sw_next[gpc_pkg::SW_AT_OUTER] = at_outer_s;
    sw_next[gpc_pkg::SW_AT_INNER] = at_inner_s;
    sw_next[gpc_pkg::SW_AT_TEACH] = at_teach;
    sw_next[gpc_pkg::SW_UNDEF] = !(at_outer_s || at_inner_s || at_teach);
    sw_next[gpc_pkg::SW_TAKEOVER_ACK] = takeover_ack_reg;
    sw_next[gpc_pkg::SW_DIR_OUTER] = dir_outer_reg;
    sw_next[gpc_pkg::SW_DIR_INNER] = dir_inner_reg;
    sw_next[gpc_pkg::SW_FAULT] = (fault_reg != gpc_pkg::FAULT_NONE);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sw_reg <= 16'h0;
      fc_reg <= 16'h0;
      jp_reg <= 16'h0;
    end else begin
      sw_reg <= sw_next;
      fc_reg <= fault_reg;
      jp_reg <= jaw_s;
    end
  end
  assign state_word = sw_reg;
  assign fault_code = fc_reg;
  assign jaw_position_now = jp_reg;

  property p_take_ack;
    @(posedge clk_sys) disable iff (!resetn) do_take |=> takeover_ack_reg;
  endproperty
  a_take_ack: assert property (p_take_ack) else $error("takeover not acknowledged");
  property p_stop_clear;
    @(posedge clk_sys) disable iff (!resetn) do_stop |-> ##2 !state_word[12];
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("ack not cleared");
  property p_clear_dir;
    @(posedge clk_sys) disable iff (!resetn) do_clear |=> !dir_outer_reg && !dir_inner_reg;
  endproperty
  a_clear_dir: assert property (p_clear_dir) else $error("direction kept");
  property p_cal;
    @(posedge clk_sys) disable iff (!resetn) calibrate |-> $past(cmd_reg) == 16'h0080;
  endproperty
  a_cal: assert property (p_cal) else $error("calibrate without code");
  sequence s_outer_run;
    move_outer ##1 state_word[gpc_pkg::SW_DIR_OUTER];
  endsequence
  property p_outer;
    @(posedge clk_sys) disable iff (!resetn) start_outer |=> s_outer_run;
  endproperty
  a_outer: assert property (p_outer) else $error("outer move missing");
  property p_ack;
    @(posedge clk_sys) disable iff (!resetn)
      do_ack && fault_res_reg && fault_in == 16'h0 && !lost_evt |=> fault_reg == 16'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("fault not cleared");
  property p_fault_bit;
    @(posedge clk_sys) disable iff (!resetn) state_word[15] == (fault_code != 16'h0);
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault bit mismatch");
  property p_ignore;
    @(posedge clk_sys) disable iff (!resetn)
      tick && !cmd_ok |=> $stable(takeover_ack_reg) && $stable(dir_outer_reg) &&
        $stable(dir_inner_reg);
  endproperty
  a_ignore: assert property (p_ignore) else $error("invalid command acted on");
endmodule // gpc_top

// File: verif/gpc_master_model.sv
// cyclic master model: output process data and the take-over handshake
`timescale 1ns/1ps
module gpc_master_model #(
  parameter int CYC = 8 // clocks per exchange cycle
) (
  input wire logic clk_sys, // system clock
  input wire logic [15:0] state_word, // state word from device
  output logic [15:0] command_word, // command word
  output logic [7:0] travel_profile_code, // travel profile
  output logic [7:0] recipe_index, // recipe selection
  output logic [15:0] expected_part_position, // expected position
  output logic [7:0] force_level, // force level
  output logic [7:0] position_window // position window
);
  localparam int LIM = 6 * CYC;
  initial begin
    command_word = 16'h0000;
    travel_profile_code = 8'h00;
    recipe_index = 8'h00;
    expected_part_position = 16'h0000;
    force_level = 8'h00;
    position_window = 8'h00;
  end
  task automatic set_par(input logic [7:0] prof, input logic [7:0] rec, input logic [7:0] frc,
    input logic [7:0] win, input logic [15:0] pos);
    @(posedge clk_sys);
    travel_profile_code <= prof;
    recipe_index <= rec;
    force_level <= frc;
    position_window <= win;
    expected_part_position <= pos;
  endtask
  task automatic cmd(input logic [15:0] c);
    @(posedge clk_sys);
    command_word <= c;
  endtask
  task automatic wait_ack(input logic v, inout bit ok);
    int k;
    k = 0;
    while (state_word[gpc_pkg::SW_TAKEOVER_ACK] !== v && k < LIM) begin
      @(posedge clk_sys);
      k++;
    end
    ok = ok && (k < LIM);
  endtask
  task automatic take_over(output bit ok);
    ok = 1'b1;
    cmd(gpc_pkg::CMD_TAKE_OVER);
    wait_ack(1'b1, ok);
    cmd(gpc_pkg::CMD_IDLE);
    wait_ack(1'b0, ok);
  endtask
  task automatic boot_ok(output bit ok);
    ok = (state_word[gpc_pkg::SW_BOOT] === 1'b1);
  endtask
endmodule // gpc_master_model

// File: verif/tb.sv
// self-checking bench for the process data command interpreter
`timescale 1ns/1ps
module tb;
  localparam int CYC = 8;
  localparam int IDL = 3 * CYC + 4;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] jaw_pos_in = 16'h0000;
  logic at_outer_in = 1'b0;
  logic at_inner_in = 1'b0;
  logic part_lost_in = 1'b0;
  logic [15:0] fault_in = 16'h0000;
  logic fault_resettable_in = 1'b0;
  wire logic [15:0] command_word, expected_part_position, state_word, fault_code;
  wire logic [15:0] jaw_position_now, active_position;
  wire logic [7:0] travel_profile_code, recipe_index, force_level, position_window;
  wire logic [7:0] active_force, active_window;
  wire logic move_outer, move_inner, grip_force_move, hold_feed, calibrate;
  wire logic [20:0] obs = {calibrate, hold_feed, grip_force_move, move_inner, move_outer,
    state_word};
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int rf[33];
  int rw[33];
  int rp[33];
  int cf, cw, cp, cr, jp, k;
  bit ok;
  logic [15:0] lf = 16'h0015;
  logic [15:0] bad [2] = '{16'h0003, 16'h0300};

  gpc_top #(.CYCLE_CLKS(CYC), .REDUCED(1'b0)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .command_word(command_word), .travel_profile_code(travel_profile_code),
    .recipe_index(recipe_index), .expected_part_position(expected_part_position),
    .force_level(force_level), .position_window(position_window), .jaw_pos_in(jaw_pos_in),
    .at_outer_in(at_outer_in), .at_inner_in(at_inner_in), .part_lost_in(part_lost_in),
    .fault_in(fault_in), .fault_resettable_in(fault_resettable_in), .state_word(state_word),
    .fault_code(fault_code), .jaw_position_now(jaw_position_now), .move_outer(move_outer),
    .move_inner(move_inner), .grip_force_move(grip_force_move), .hold_feed(hold_feed),
    .calibrate(calibrate), .active_force(active_force), .active_window(active_window),
    .active_position(active_position));

  gpc_master_model #(.CYC(CYC)) m (.clk_sys(clk_sys), .state_word(state_word),
    .command_word(command_word), .travel_profile_code(travel_profile_code),
    .recipe_index(recipe_index), .expected_part_position(expected_part_position),
    .force_level(force_level), .position_window(position_window));

  always #10 clk_sys = ~clk_sys;

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic idle();
    repeat (IDL) @(posedge clk_sys);
    #1;
  endtask

  // waits a bounded time for one observed bit, then compares it
  task automatic wb(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk($sformatf("obs bit %0d", i), 16'(v), 16'(obs[i]));
  endtask

  task automatic op(input logic [15:0] c);
    m.cmd(c);
    idle();
    m.cmd(gpc_pkg::CMD_IDLE);
    idle();
  endtask

  task automatic par(input logic [7:0] prof, input logic [7:0] rec);
    lf = nxt(lf);
    cf = 1 + int'(lf[1:0]);
    cw = int'(lf[15:8]);
    lf = nxt(lf);
    cp = int'(lf[11:0]);
    cr = int'(rec);
    m.set_par(prof, rec, 8'(cf), 8'(cw), 16'(cp));
  endtask

  task automatic tko();
    m.take_over(ok);
    chk("handshake", 16'h0001, 16'(ok));
    repeat (2) @(posedge clk_sys);
    #1;
    chk("active_force", 16'(cr == 0 ? cf : rf[cr]), 16'(active_force));
    chk("active_window", 16'(cr == 0 ? cw : rw[cr]), 16'(active_window));
    chk("active_position", 16'(cr == 0 ? cp : rp[cr]), active_position);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    lf = nxt(lf);
    jp = int'(lf[11:0]);
    jaw_pos_in = 16'(jp);
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    m.boot_ok(ok);
    chk("boot flag", 16'h0001, 16'(ok));
    chk("reset force", 16'(gpc_pkg::FORCE_RESET), 16'(active_force));
    chk("reset fault", 16'h0000, 16'(state_word[15]));
    $display("test reset done");
    par(gpc_pkg::PROF_60, 8'h00);
    tko();
    chk("jaw position", 16'(jp), jaw_position_now);
    par(gpc_pkg::PROF_60, 8'h05);
    op(gpc_pkg::CMD_STORE_RECIPE);
    rf[5] = cf;
    rw[5] = cw;
    rp[5] = cp;
    op(gpc_pkg::CMD_TEACH);
    rp[5] = jp;
    par(gpc_pkg::PROF_100, 8'h00);
    tko();
    par(gpc_pkg::PROF_70, 8'h05);
    tko();
    $display("test recipes done");
    for (int d = 0; d < 2; d++) begin
      m.cmd(d == 1 ? gpc_pkg::CMD_GO_OUTER : gpc_pkg::CMD_GO_INNER);
      wb(17 - d, 1'b1, 40);
      chk("grip_force_move", 16'(d == 0), 16'(grip_force_move));
      @(posedge clk_sys);
      at_inner_in <= (d == 0);
      at_outer_in <= (d == 1);
      wb(17 - d, 1'b0, 20);
      m.cmd(gpc_pkg::CMD_IDLE);
      idle();
      chk("dir inner", 16'(d == 0), 16'(state_word[14]));
      chk("dir outer", 16'(d == 1), 16'(state_word[13]));
      chk("at end", 16'h0001, 16'(state_word[10 - 2 * d]));
      chk("hold 60", 16'h0000, 16'(hold_feed));
    end
    m.cmd(gpc_pkg::CMD_GO_OUTER);
    idle();
    chk("repeat outer", 16'h0000, 16'(move_outer));
    m.cmd(gpc_pkg::CMD_IDLE);
    idle();
    op(gpc_pkg::CMD_CLEAR_DIR);
    chk("dir cleared", 16'h0000, {14'h0000, state_word[14:13]});
    $display("test moves done");
    for (int b = 0; b < 2; b++) begin
      m.cmd(bad[b]);
      idle();
      chk("ack on bad word", 16'h0000, 16'(state_word[12]));
      chk("move on bad word", 16'h0000, 16'(move_inner));
      m.cmd(gpc_pkg::CMD_IDLE);
      idle();
    end
    m.cmd(gpc_pkg::CMD_CALIBRATE);
    wb(20, 1'b1, 40);
    m.cmd(gpc_pkg::CMD_IDLE);
    idle();
    $display("test commands done");
    par(gpc_pkg::PROF_103, 8'h00);
    tko();
    m.cmd(gpc_pkg::CMD_GO_INNER);
    wb(17, 1'b1, 40);
    @(posedge clk_sys);
    at_outer_in <= 1'b0;
    at_inner_in <= 1'b1;
    wb(19, 1'b1, 40);
    k = 0;
    while (hold_feed !== 1'b0 && k < 1000) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("hold length", 16'h0001, 16'(k >= (gpc_pkg::HOLD_CYCLES - 1) * CYC &&
      k <= (gpc_pkg::HOLD_CYCLES + 1) * CYC));
    m.cmd(gpc_pkg::CMD_IDLE);
    idle();
    m.cmd(gpc_pkg::CMD_GO_OUTER);
    wb(16, 1'b1, 40);
    @(posedge clk_sys);
    at_inner_in <= 1'b0;
    at_outer_in <= 1'b1;
    wb(19, 1'b1, 40);
    @(posedge clk_sys);
    part_lost_in <= 1'b1;
    wb(15, 1'b1, 60);
    chk("lost code", gpc_pkg::FAULT_PART_LOST, fault_code);
    @(posedge clk_sys);
    part_lost_in <= 1'b0;
    m.cmd(gpc_pkg::CMD_IDLE);
    idle();
    op(gpc_pkg::CMD_FAULT_ACK);
    chk("fault cleared", 16'h0000, {state_word[15], fault_code[14:0]});
    @(posedge clk_sys);
    fault_in <= 16'h0007;
    fault_resettable_in <= 1'b0;
    wb(15, 1'b1, 40);
    chk("fault code", 16'h0007, fault_code);
    op(gpc_pkg::CMD_FAULT_ACK);
    chk("fault kept", 16'h0001, 16'(state_word[15]));
    $display("test faults done");
    end_of_test();
  end
endmodule // tb
